// ### logic/asp_pkg.sv
// Purpose: Shared constants and types for the master-mode serial audio port.
// Assumes: A 200 MHz system clock and a 1 ms start-of-frame period.
// Notes: Clock rates are in kHz so that divider ratios stay exact integers.
package asp_pkg;

  // System clock and the fixed master clock.
  localparam int unsigned CLK_PERIOD_PS = 32'h0000_1388;
  localparam int unsigned SYS_CLK_KHZ = 1000000000 / CLK_PERIOD_PS;
  localparam int unsigned MCLK_KHZ = 32'h0000_2ee0;

  // Phase accumulator: one toggle tick per master clock half period.
  localparam int unsigned ACC_W = 18;
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_KHZ);
  localparam logic [ACC_W-1:0] INC_NOM = ACC_W'(2 * MCLK_KHZ);
  localparam logic [ACC_W-1:0] TRIM_MAX = ACC_W'(INC_NOM / 100);

  // Start-of-frame period and the toggle ticks expected within it.
  localparam int unsigned SOF_PERIOD_US = 32'h0000_03e8;
  localparam int unsigned SOF_CNT_W = 16;
  localparam logic [SOF_CNT_W-1:0] SOF_TICKS_NOM = SOF_CNT_W'(2 * MCLK_KHZ * SOF_PERIOD_US / 1000);

  // Master clock to channel clock ratios.
  localparam int unsigned DIV_48K = 32'h0000_00fa;
  localparam int unsigned DIV_44K = 32'h0000_0110;

  // Toggle ticks per bit clock half period, and the bit slots per channel half.
  localparam logic [2:0] HB_48K = 3'h5;
  localparam logic [2:0] HB_44K = 3'h4;
  localparam logic [5:0] SLOTS_48K = 6'(DIV_48K / (2 * HB_48K));
  localparam logic [5:0] SLOTS_44K = 6'(DIV_44K / (2 * HB_44K));

  // Sample word widths.
  localparam logic [5:0] WIDTH_16 = 6'h10;
  localparam logic [5:0] WIDTH_24 = 6'h18;
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned PAIR_W = 2 * SAMPLE_W;

  // Isochronous streaming endpoint that carries the audio.
  localparam logic [3:0] EP_AUDIO = 4'h3;

  // Values after reset.
  localparam logic RATE_44K_RST = 1'b0;
  localparam logic WIDE_RST = 1'b0;
  localparam logic SYNC_RST = 1'b0;

  typedef enum logic [1:0] {
    ASP_PLAY_REC,
    ASP_PLAY_ONLY,
    ASP_REC_ONLY
  } asp_dir_t;

endpackage : asp_pkg

// ### logic/asp_pair_buf.sv
// Purpose: Two-entry buffer for stereo sample pairs with valid and ready on both sides.
// Assumes: One clock, synchronous active-low reset.
// Notes: The head entry is the output register, so read data always come from a flop.
`timescale 1ns/1ps
module asp_pair_buf #(
  parameter int unsigned WIDTH = 48
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic head_valid_q;
  logic [WIDTH-1:0] head_q;
  logic spare_valid_q;
  logic [WIDTH-1:0] spare_q;
  logic push;
  logic pop;

  // Only the spare slot limits intake, so a stalled drain fills both entries.
  assign in_ready = !spare_valid_q;
  assign out_valid = head_valid_q;
  assign out_data = head_q;
  assign push = in_valid && in_ready;
  assign pop = head_valid_q && out_ready;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      head_valid_q <= 1'b0;
      head_q <= '0;
      spare_valid_q <= 1'b0;
      spare_q <= '0;
    end else if (!head_valid_q || pop) begin
      if (spare_valid_q) begin
        head_q <= spare_q;
        head_valid_q <= 1'b1;
        spare_valid_q <= push;
        if (push) begin
          spare_q <= in_data;
        end
      end else begin
        head_valid_q <= push;
        if (push) begin
          head_q <= in_data;
        end
      end
    end else if (push) begin
      spare_q <= in_data;
      spare_valid_q <= 1'b1;
    end
  end

endmodule : asp_pair_buf

// ### logic/asp_port.sv
// Purpose: Master-mode stereo serial audio port toward a slave converter.
// Assumes: 200 MHz clk; stream and start-of-frame inputs come from logic on clk.
// Notes: Converter clocks come from a fractional phase accumulator, so edges
//   carry one system clock period of jitter; the average rates are exact.
`timescale 1ns/1ps

// Functional notes
// - A 12 MHz master clock runs continuously toward the converter.
// - Channel clock level tells whether the left or right word is shifting.
// - Channel clock makes one full period per sample frame.
// - Channel clock is an integer division of the master clock source.
// - Data are valid at the bit clock rising edge and change on falling.
// - Playback words shift out; record words are captured from the converter.
// - The port always generates channel and bit clocks as outputs.
// - Only 44.1 and 48 kHz; both directions share one rate.
// - Ratio is 250 for 48 kHz and 272 for 44.1 kHz.
// - Exactly one direction mode: play and record, play only, record only.
// - Play and record together always use 16-bit words.
// - Play-only mode selects 24-bit or 16-bit words.
// - Record-only mode selects 24-bit or 16-bit words.
// - Synchronous or asynchronous endpoint timing is selectable in every mode.
// - Synchronous mode trims the clocks to follow start-of-frame arrival.
// - Asynchronous mode leaves the clocks untrimmed.
// - Audio travels over streaming endpoint 3.
module asp_port
  import asp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Configuration, sampled at each frame start.
  input wire asp_dir_t dir_mode,
  input wire logic wide_words,
  input wire logic rate_44k,
  input wire logic sync_mode,
  // Start-of-frame strobe from the USB side.
  input wire logic sof_pulse,
  // Playback stream in: {left, right}, samples left-aligned in 24 bits.
  input wire logic play_valid,
  output logic play_ready,
  input wire logic [3:0] play_ep,
  input wire logic [PAIR_W-1:0] play_data,
  // Record stream out: {left, right}, samples left-aligned in 24 bits.
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [PAIR_W-1:0] rec_data,
  // Converter pins.
  output logic master_clk,
  output logic chan_clk,
  output logic bit_clk,
  output logic serial_data_to_converter,
  input wire logic serial_data_from_converter,
  // Status.
  input wire logic clr_status,
  output logic underrun,
  output logic overrun,
  output logic [ACC_W-1:0] clk_increment
);

  // Picks the bit for a slot of one channel; slot 1 carries the MSB.
  function automatic logic pick_bit(input logic [PAIR_W-1:0] pair, input logic right,
                                    input logic [5:0] slot, input logic [5:0] width);
    logic [SAMPLE_W-1:0] word;
    logic [4:0] idx;
    word = right ? pair[SAMPLE_W-1:0] : pair[PAIR_W-1:SAMPLE_W];
    idx = 5'(6'(SAMPLE_W) - slot);
    if ((slot != 6'h0) && (slot <= width)) begin
      pick_bit = word[idx];
    end else begin
      pick_bit = 1'b0;
    end
  endfunction : pick_bit

  // Active configuration, held for a whole frame.
  asp_dir_t dir_q;
  logic wide_q;
  logic rate_44k_q;
  logic sync_q;

  // Clock generation state.
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] inc_q;
  logic [ACC_W:0] acc_sum;
  logic tog_en;
  logic master_clk_q;
  logic [2:0] hb_cnt_q;
  logic bit_clk_q;
  logic [5:0] slot_q;
  logic chan_q;
  logic [SOF_CNT_W-1:0] sof_cnt_q;

  // Derived timing and events.
  logic [2:0] hb_lim;
  logic [5:0] slot_lim;
  logic hb_wrap;
  logic fall_ev;
  logic rise_ev;
  logic [5:0] slot_nx;
  logic chan_nx;
  logic frame_start;
  logic [5:0] width;
  logic play_on;
  logic rec_on;

  // Data path state.
  logic [PAIR_W-1:0] play_word_q;
  logic sdout_q;
  logic [2:0] sdin_sync_q;
  logic sdin_q;
  logic [SAMPLE_W-1:0] cap_q;
  logic [SAMPLE_W-1:0] cap_word;
  logic [SAMPLE_W-1:0] left_q;
  logic rec_push_q;
  logic [PAIR_W-1:0] rec_word_q;
  logic underrun_q;
  logic overrun_q;

  // Buffer hookup.
  logic pbuf_in_valid;
  logic pbuf_in_ready;
  logic pbuf_out_valid;
  logic pbuf_out_ready;
  logic [PAIR_W-1:0] pbuf_out_data;
  logic rbuf_in_ready;
  logic play_take;
  logic play_drop;

  // Rate picks the bit clock and slot count; both give the documented ratio.
  assign hb_lim = rate_44k_q ? HB_44K : HB_48K;
  assign slot_lim = rate_44k_q ? SLOTS_44K : SLOTS_48K;
  assign play_on = (dir_q != ASP_REC_ONLY);
  assign rec_on = (dir_q != ASP_PLAY_ONLY);
  // The bidirectional mode cannot carry 24-bit words.
  assign width = (wide_q && (dir_q != ASP_PLAY_REC)) ? WIDTH_24 : WIDTH_16;

  // Fractional divider: one tick per master clock half period on average.
  assign acc_sum = {1'b0, acc_q} + {1'b0, inc_q};
  assign tog_en = (acc_sum >= {1'b0, ACC_MOD});

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_q <= '0;
    end else if (tog_en) begin
      acc_q <= ACC_W'(acc_sum - {1'b0, ACC_MOD});
    end else begin
      acc_q <= acc_sum[ACC_W-1:0];
    end
  end

  // The master clock never stops, whatever the stream state.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      master_clk_q <= 1'b0;
    end else if (tog_en) begin
      master_clk_q <= !master_clk_q;
    end
  end

  // Start-of-frame tracking. Ticks are counted per frame period and the
  // increment nudged by one step, which keeps the loop slow and free of
  // audible jumps; the trim range is clamped to one percent.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sof_cnt_q <= '0;
    end else if (sof_pulse) begin
      sof_cnt_q <= '0;
    end else if (tog_en && (sof_cnt_q != '1)) begin
      sof_cnt_q <= sof_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inc_q <= INC_NOM;
    end else if (!sync_q) begin
      inc_q <= INC_NOM;
    end else if (sof_pulse) begin
      if ((sof_cnt_q < SOF_TICKS_NOM) && (inc_q < INC_NOM + TRIM_MAX)) begin
        inc_q <= inc_q + 1'b1;
      end else if ((sof_cnt_q > SOF_TICKS_NOM) && (inc_q > INC_NOM - TRIM_MAX)) begin
        inc_q <= inc_q - 1'b1;
      end
    end
  end

  // The bit clock counts master clock ticks; the channel clock counts bit clock falls.
  assign hb_wrap = tog_en && (hb_cnt_q == hb_lim - 3'h1);
  assign fall_ev = hb_wrap && bit_clk_q;
  assign rise_ev = hb_wrap && !bit_clk_q;
  assign slot_nx = (slot_q >= slot_lim - 6'h1) ? 6'h0 : slot_q + 6'h1;
  assign chan_nx = (slot_nx == 6'h0) ? !chan_q : chan_q;
  assign frame_start = fall_ev && (slot_nx == 6'h0) && !chan_nx;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hb_cnt_q <= '0;
      bit_clk_q <= 1'b0;
    end else if (hb_wrap) begin
      hb_cnt_q <= '0;
      bit_clk_q <= !bit_clk_q;
    end else if (tog_en) begin
      hb_cnt_q <= hb_cnt_q + 3'h1;
    end
  end

  // The channel clock changes with a falling bit clock edge only.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slot_q <= '0;
      chan_q <= 1'b0;
    end else if (fall_ev) begin
      slot_q <= slot_nx;
      chan_q <= chan_nx;
    end
  end

  // Configuration is taken only at a frame start, so a frame never mixes rates.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dir_q <= ASP_PLAY_REC;
      wide_q <= WIDE_RST;
      rate_44k_q <= RATE_44K_RST;
      sync_q <= SYNC_RST;
    end else if (frame_start) begin
      dir_q <= dir_mode;
      wide_q <= wide_words;
      rate_44k_q <= rate_44k;
      sync_q <= sync_mode;
    end
  end

  // Playback buffer. Words for other endpoints, or while playback is off,
  // are accepted and dropped so the stream source never hangs.
  assign play_drop = (play_ep != EP_AUDIO) || !play_on;
  assign pbuf_in_valid = play_valid && !play_drop;
  assign play_ready = play_drop || pbuf_in_ready;
  assign play_take = frame_start && play_on && pbuf_out_valid;
  assign pbuf_out_ready = frame_start;

  asp_pair_buf #(
    .WIDTH(PAIR_W)
  ) u_play_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(pbuf_in_valid),
    .in_ready(pbuf_in_ready),
    .in_data(play_data),
    .out_valid(pbuf_out_valid),
    .out_ready(pbuf_out_ready),
    .out_data(pbuf_out_data)
  );

  // A new pair is loaded at each frame start; without one the frame is silent.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      play_word_q <= '0;
    end else if (frame_start) begin
      play_word_q <= play_take ? pbuf_out_data : '0;
    end
  end

  // Output data change on the falling edge, one slot after the channel change.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sdout_q <= 1'b0;
    end else if (fall_ev) begin
      if (!play_on) begin
        sdout_q <= 1'b0;
      end else if (frame_start) begin
        sdout_q <= pick_bit(play_take ? pbuf_out_data : '0, chan_nx, slot_nx, width);
      end else begin
        sdout_q <= pick_bit(play_word_q, chan_nx, slot_nx, width);
      end
    end
  end

  // The data pin is asynchronous to clk; a change counts once two stages agree.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sdin_sync_q <= '0;
      sdin_q <= 1'b0;
    end else begin
      sdin_sync_q <= {sdin_sync_q[1:0], serial_data_from_converter};
      if (sdin_sync_q[1] == sdin_sync_q[2]) begin
        sdin_q <= sdin_sync_q[2];
      end
    end
  end

  // Capture shifts on the rising edge; short words are left-aligned.
  assign cap_word = (width == WIDTH_24) ? {cap_q[SAMPLE_W-2:0], sdin_q}
                                        : {cap_q[14:0], sdin_q, 8'h00};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_q <= '0;
      left_q <= '0;
      rec_push_q <= 1'b0;
      rec_word_q <= '0;
    end else begin
      rec_push_q <= 1'b0;
      if (rise_ev && rec_on && (slot_q != 6'h0) && (slot_q <= width)) begin
        cap_q <= {cap_q[SAMPLE_W-2:0], sdin_q};
        if (slot_q == width) begin
          if (!chan_q) begin
            left_q <= cap_word;
          end else begin
            rec_word_q <= {left_q, cap_word};
            rec_push_q <= 1'b1;
          end
        end
      end
    end
  end

  asp_pair_buf #(
    .WIDTH(PAIR_W)
  ) u_rec_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rec_push_q),
    .in_ready(rbuf_in_ready),
    .in_data(rec_word_q),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );

  // Sticky status; a new event in the clearing cycle keeps its flag set.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      underrun_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (frame_start && play_on && !pbuf_out_valid) begin
        underrun_q <= 1'b1;
      end else if (clr_status) begin
        underrun_q <= 1'b0;
      end
      if (rec_push_q && !rbuf_in_ready) begin
        overrun_q <= 1'b1;
      end else if (clr_status) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // Every converter clock is an output; nothing here listens to the far end.
  assign master_clk = master_clk_q;
  assign chan_clk = chan_q;
  assign bit_clk = bit_clk_q;
  assign serial_data_to_converter = sdout_q;
  assign underrun = underrun_q;
  assign overrun = overrun_q;
  assign clk_increment = inc_q;

endmodule : asp_port

// ### tb/asp_port_asserts.sv
// Purpose: Checker bound to the serial audio port.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Half-frame counters let the divider ratios be judged despite edge jitter.
`timescale 1ns/1ps
module asp_port_asserts
  import asp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Streams and status.
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire logic [PAIR_W-1:0] rec_data,
  input wire logic clr_status,
  input wire logic underrun,
  input wire logic overrun,
  input wire logic [ACC_W-1:0] clk_increment,
  // Converter pins.
  input wire logic master_clk,
  input wire logic chan_clk,
  input wire logic bit_clk,
  input wire logic serial_data_to_converter
);
  logic [8:0] mcnt_q;
  logic [5:0] bcnt_q;
  logic seen_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // The first half after reset is partial, so it is never judged.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mcnt_q <= '0;
      bcnt_q <= '0;
      seen_q <= 1'b0;
    end else if ($changed(chan_clk)) begin
      mcnt_q <= 9'($rose(master_clk));
      bcnt_q <= 6'($rose(bit_clk));
      seen_q <= 1'b1;
    end else begin
      mcnt_q <= mcnt_q + 9'($rose(master_clk));
      bcnt_q <= bcnt_q + 6'($rose(bit_clk));
    end
  end

  sequence mclk_half_s;
    $stable(master_clk) [*7] ##[1:2] $changed(master_clk);
  endsequence

  reset_quiet_a:
    assert property (disable iff (1'b0) !reset_n |=> !master_clk && !chan_clk && !bit_clk && !rec_valid)
    else $error("Port outputs not cleared by reset.");
  mclk_runs_a:
    assert property (1'b1 |-> ##[1:12] $changed(master_clk))
    else $error("Master clock stopped.");
  mclk_period_a:
    assert property ($changed(master_clk) |=> mclk_half_s)
    else $error("Master clock half period out of range.");
  bclk_tied_a:
    assert property ($changed(bit_clk) |-> $changed(master_clk))
    else $error("Bit clock moved without a master clock edge.");
  chan_on_fall_a:
    assert property ($changed(chan_clk) |-> $fell(bit_clk))
    else $error("Channel clock moved off a bit clock fall.");
  data_off_rise_a:
    assert property ($changed(serial_data_to_converter) |-> !bit_clk)
    else $error("Serial output changed while bit clock high.");
  half_ratio_a:
    assert property ($changed(chan_clk) && seen_q |-> (mcnt_q == 9'(DIV_48K / 2) && bcnt_q == SLOTS_48K) ||
      (mcnt_q == 9'(DIV_44K / 2) && bcnt_q == SLOTS_44K))
    else $error("Channel half holds a wrong count of master or bit periods.");
  rec_holds_a:
    assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("Record pair withdrawn before it was taken.");
  flags_stick_a:
    assert property (!clr_status |=> (underrun || !$past(underrun)) && (overrun || !$past(overrun)))
    else $error("Status flag dropped without a clear.");
  trim_range_a:
    assert property ($past(reset_n) |-> clk_increment <= INC_NOM + TRIM_MAX && clk_increment >= INC_NOM - TRIM_MAX)
    else $error("Clock increment outside its trim range.");
endmodule : asp_port_asserts

bind asp_port asp_port_asserts asp_port_asserts_i (.clk, .reset_n, .rec_valid, .rec_ready, .rec_data, .clr_status,
  .underrun, .overrun, .clk_increment, .master_clk, .chan_clk, .bit_clk, .serial_data_to_converter);

// ### tb/asp_conv_model.sv
// Purpose: Slave converter model that hears playback and sends record words.
// Assumes: The port drives both clocks; the bench sets the word width per run.
// Notes: Outside its slots the model toggles its data line so stale bits never pass.
`timescale 1ns/1ps
module asp_conv_model
  import asp_pkg::*;
(
  // Bench control.
  input wire logic reset_n,
  input wire logic [5:0] width,
  input wire logic [PAIR_W-1:0] tx_pair,
  // Port clocks, only ever read here.
  input wire logic chan_clk,
  input wire logic bit_clk,
  // Serial data.
  input wire logic serial_data_to_converter,
  output logic serial_data_from_converter,
  // Last whole pair heard, and left halves started.
  output logic [PAIR_W-1:0] rx_pair,
  output int frames
);
  logic prev;
  logic [PAIR_W-1:0] tx_q;
  logic [PAIR_W-1:0] cap_q;
  int slot;
  int msb;

  // Both port clocks move in the same time step, so the channel clock is read 1 ns later.
  // Testing reset after the wait keeps a reset that lands in the same step from being lost.
  always @(negedge bit_clk or negedge reset_n) begin
    #1;
    if (!reset_n) begin
      frames = 0;
      prev = 1'b0;
      slot = 0;
      msb = 48;
      rx_pair = '0;
      cap_q = '0;
      tx_q = tx_pair;
      serial_data_from_converter = 1'b0;
    end else begin
      slot = (chan_clk != prev) ? 0 : slot + 1;
      if (chan_clk != prev && !chan_clk) begin
        if (frames > 0) rx_pair = cap_q;
        cap_q = '0;
        tx_q = tx_pair;
        frames = frames + 1;
      end
      prev = chan_clk;
      msb = chan_clk ? 24 : 48;
      if (slot >= 1 && slot <= width) serial_data_from_converter = tx_q[msb - slot];
      else serial_data_from_converter = !serial_data_from_converter;
    end
  end

  always @(posedge bit_clk) begin
    if (reset_n && slot >= 1 && slot <= width) cap_q[msb - slot] = serial_data_to_converter;
  end
endmodule : asp_conv_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the serial audio port.
// Assumes: Each run resets the port with its configuration already applied.
// Notes: Checks start two frames after reset, once the new configuration is latched.
`timescale 1ns/1ps
module tb_top;
  import asp_pkg::*;
  logic clk, reset_n, wide_words, rate_44k, sync_mode, sof_pulse, play_valid, rec_ready, clr_status, stall;
  logic play_ready, rec_valid, master_clk, chan_clk, bit_clk, underrun, overrun;
  logic serial_data_to_converter, serial_data_from_converter;
  asp_dir_t dir_mode;
  logic [3:0] play_ep;
  logic [PAIR_W-1:0] play_data, rec_data, tx_pair, rx_pair, exp_d;
  logic [ACC_W-1:0] clk_increment;
  logic [5:0] width;
  logic [31:0] seed, rr;
  int errors, samples_checked, cycles, frames, last_frames, i;
  logic [PAIR_W-1:0] play_q[$];
  asp_dir_t dirs[4] = '{ASP_PLAY_REC, ASP_PLAY_ONLY, ASP_REC_ONLY, ASP_REC_ONLY};
  logic [3:0] wides = 4'h7;
  logic [3:0] r44s = 4'ha;
  logic [3:0] stalls = 4'h4;

  asp_port asp_port_i (.clk, .reset_n, .dir_mode, .wide_words, .rate_44k, .sync_mode, .sof_pulse, .play_valid,
    .play_ready, .play_ep, .play_data, .rec_valid, .rec_ready, .rec_data, .master_clk, .chan_clk, .bit_clk,
    .serial_data_to_converter, .serial_data_from_converter, .clr_status, .underrun, .overrun, .clk_increment);
  asp_conv_model asp_conv_model_i (.reset_n, .width, .tx_pair, .chan_clk, .bit_clk, .serial_data_to_converter,
    .serial_data_from_converter, .rx_pair, .frames);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [PAIR_W-1:0] keep(input logic [PAIR_W-1:0] v, input logic [5:0] w);
    logic [23:0] m;
    m = 24'hff_ffff << (WIDTH_24 - w);
    return v & {m, m};
  endfunction : keep

  task automatic check(input string what, input logic [PAIR_W-1:0] exp, input logic [PAIR_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic wait_frames(input int n);
    while (frames < n) @(negedge clk);
    repeat (8) @(negedge clk);
  endtask : wait_frames

  task automatic clear_flags();
    @(posedge clk);
    clr_status <= 1'b1;
    @(posedge clk);
    clr_status <= 1'b0;
    @(negedge clk);
  endtask : clear_flags

  task automatic offer(input logic [3:0] ep);
    seed = xs(seed);
    @(posedge clk);
    play_ep <= ep;
    play_data <= {1'b1, seed[22:0], seed[31:8]};
    play_valid <= 1'b1;
    @(negedge clk);
    while (play_ready !== 1'b1) @(negedge clk);
    if (ep == EP_AUDIO && dir_mode != ASP_REC_ONLY) play_q.push_back(keep(play_data, width));
    @(posedge clk);
    play_valid <= 1'b0;
  endtask : offer

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Stall, start-of-frame and record-side stimulus, plus the hang guard.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rr <= xs(rr);
    rec_ready <= !(stall && frames >= 2 && frames < 5) && rr[3];
    sof_pulse <= (cycles % 32'h0000_0bb8) == 0;
    if (rec_valid && rec_ready && frames >= 2) begin
      if (dir_mode != ASP_PLAY_ONLY) check("rec_data", keep(tx_pair, width), rec_data);
      else check("rec_valid", 0, rec_valid);
    end
    if (frames != last_frames) begin
      last_frames <= frames;
      if (frames >= 2 && dir_mode == ASP_REC_ONLY) check("silence", 0, rx_pair);
      else if (frames >= 2 && rx_pair !== '0) begin
        exp_d = (play_q.size() > 0) ? play_q.pop_front() : '1;
        check("play_pair", exp_d, rx_pair);
      end
    end
    // The hang guard comes last, so nothing in this process runs after the run ends.
    if (cycles >= 32'h0001_d4c0) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    dir_mode = ASP_PLAY_REC;
    {wide_words, rate_44k, sync_mode, sof_pulse, play_valid, rec_ready, clr_status, stall} = '0;
    play_ep = 4'h0;
    play_data = '0;
    tx_pair = '0;
    width = WIDTH_16;
    seed = 32'h0000_6d6d;
    rr = 32'h0000_6d6d;
    {errors, samples_checked, cycles, last_frames} = '0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      reset_n <= 1'b0;
      dir_mode <= dirs[i];
      wide_words <= wides[i];
      rate_44k <= r44s[i];
      sync_mode <= r44s[i];
      stall <= stalls[i];
      width <= (dirs[i] == ASP_PLAY_REC || !wides[i]) ? WIDTH_16 : WIDTH_24;
      seed = xs(seed);
      tx_pair <= {seed[23:0], seed[31:8]};
      play_q.delete();
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      wait_frames(1);
      clear_flags();
      wait_frames(2);
      check("underrun", dirs[i] != ASP_REC_ONLY, underrun);
      clear_flags();
      check("underrun_clr", 0, underrun);
      offer(4'h5);
      offer(EP_AUDIO);
      offer(EP_AUDIO);
      @(posedge clk);
      play_valid <= 1'b1;
      @(negedge clk);
      check("play_ready", dirs[i] == ASP_REC_ONLY, play_ready);
      @(posedge clk);
      play_valid <= 1'b0;
      wait_frames(5);
      check("overrun", stalls[i], overrun);
      if (r44s[i]) check("trim_up", 1, clk_increment > INC_NOM);
      else check("trim_off", INC_NOM, clk_increment);
      repeat (40) @(negedge clk);
      check("play_left", 0, play_q.size() != 0);
    end
    stop_test();
  end
endmodule : tb_top
